// ---- rtl/ctm_clock_timer.v ----
// Clock timer: 8-bit tap counter, high nibble hold, run/clear control, APB registers.
//
// Behaviour
// - Eight-bit up-counter advanced by prescaler tick.
// - Low and high nibbles expose the taps.
// - Both count nibbles are read-only.
// - Low read freezes high nibble until read.
// - Hold window bounded to the longest limit.
// - Reset clears all eight count bits.
// - Clear bit write one zeroes; reads zero.
// - Clear written with the run bit set keeps counting from zero.
// - Run bit starts/stops; readable; resets zero.
// - Stopped counter holds value until run or a clear write.
// - Four readable mask bits, reset zero.
// - Factor flag sets on tap falling edge.
// - Flags read status; write one clears.
// - Reset clears all four factor flags.
// - Upper control bits read as zero.
`timescale 1ns/10ps
`include "ctm_consts.vh"
module ctm_clock_timer #(
	parameter HOLD_CYCLES = `CTM_HOLD_CYCLES,
	parameter CW = 8
) (
	// Clock and reset.
	input wire clock,
	input wire reset,
	// Prescaler tick, one cycle per count step.
	input wire count_tick,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Tap levels and interrupt request.
	output wire [7:0] count_tap_bits,
	output wire timer_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	reg [CW-1:0] count_ff;
	reg [CW-1:0] nxt_count;
	reg run_ff;
	reg [3:0] mask_ff;
	reg hold_ff;
	reg nxt_hold;
	reg [17:0] hold_cnt_ff;
	reg [17:0] nxt_hold_cnt;
	reg [3:0] pend_ff;
	reg [3:0] nxt_pend;
	reg [3:0] high_shown_ff;
	reg [3:0] nxt_high_shown;
	reg [31:0] nxt_rdata;
	wire access;
	wire wr;
	wire rd;
	wire sel_ctl;
	wire sel_lo;
	wire sel_hi;
	wire sel_en;
	wire sel_fl;
	wire mapped;
	wire [3:0] flags;
	wire [3:0] flag_clear;
	wire [3:0] taps;
	wire clear_req;
	wire low_carry;

	// Zero-wait slave: every access completes in its first access cycle.
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;
	assign pready = 1'b1;
	assign sel_ctl = (paddr == `CTM_ADDR_CONTROL);
	assign sel_lo = (paddr == `CTM_ADDR_COUNT_LOW);
	assign sel_hi = (paddr == `CTM_ADDR_COUNT_HIGH);
	assign sel_en = (paddr == `CTM_ADDR_IRQ_ENABLE);
	assign sel_fl = (paddr == `CTM_ADDR_IRQ_FLAGS);
	assign mapped = sel_ctl | sel_lo | sel_hi | sel_en | sel_fl;
	assign pslverr = access & ~mapped;

	// Clear strobe and flag clear come only from writes.
	assign clear_req = wr & sel_ctl & pwdata[`CTM_BIT_CLEAR];
	assign flag_clear = (wr & sel_fl) ? pwdata[3:0] : 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Counter with high nibble hold.

	// Visible taps: the low nibble live, the high nibble as last shown.
	assign count_tap_bits = {high_shown_ff, count_ff[3:0]};
	assign low_carry = count_tick & run_ff & (count_ff[3:0] == 4'hf);

	// Next count, hold window and carries pending behind the hold.
	always @* begin
		nxt_count = count_ff;
		nxt_hold = hold_ff;
		nxt_hold_cnt = hold_cnt_ff;
		nxt_pend = pend_ff;
		nxt_high_shown = high_shown_ff;
		if (run_ff && count_tick) begin
			nxt_count = count_ff + {{(CW-1){1'b0}}, 1'b1};
		end
		if (hold_ff) begin
			if (low_carry) begin
				nxt_pend = pend_ff + 4'h1;
			end
			if ((rd && sel_hi) || hold_cnt_ff == 18'd0) begin
				nxt_hold = 1'b0;
			end else begin
				nxt_hold_cnt = hold_cnt_ff - 18'd1;
			end
		end else begin
			nxt_pend = 4'h0;
			nxt_high_shown = nxt_count[7:4];
		end
		if (rd && sel_lo && !hold_ff) begin
			nxt_hold = 1'b1;
			nxt_hold_cnt = HOLD_CYCLES[17:0] - 18'd1;
			nxt_high_shown = count_ff[7:4];
		end
		if (clear_req) begin
			nxt_count = `CTM_RST_COUNT;
			nxt_pend = 4'h0;
			nxt_hold = 1'b0;
			nxt_high_shown = `CTM_RST_NIBBLE;
		end
	end

	// Counter and control state.
	always @(posedge clock) begin
		if (reset) begin
			count_ff <= `CTM_RST_COUNT;
			high_shown_ff <= `CTM_RST_NIBBLE;
			hold_ff <= 1'b0;
			hold_cnt_ff <= 18'd0;
			pend_ff <= 4'h0;
			run_ff <= 1'b0;
			mask_ff <= `CTM_RST_NIBBLE;
		end else begin
			count_ff <= nxt_count;
			high_shown_ff <= nxt_high_shown;
			hold_ff <= nxt_hold;
			hold_cnt_ff <= nxt_hold_cnt;
			pend_ff <= nxt_pend;
			if (wr && sel_ctl) begin
				run_ff <= pwdata[`CTM_BIT_RUN];
			end
			if (wr && sel_en) begin
				mask_ff <= pwdata[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt factor flags.

	// Flags follow the true counter taps, not the held view.
	assign taps = {count_ff[`CTM_TAP_1HZ], count_ff[`CTM_TAP_2HZ],
		count_ff[`CTM_TAP_8HZ], count_ff[`CTM_TAP_16HZ]};

	ctm_edge_flags #(
		.N(4)
	) u_flags (
		.clock(clock),
		.reset(reset),
		.taps(taps),
		.clear_mask(flag_clear),
		.flags(flags)
	);

	// Level request while any enabled flag stands.
	assign timer_irq = |(flags & mask_ff);

	////////////////////////////////////////////////////////////////////////////
	// Read data.

	// Read mux; data register is loaded in the setup cycle so it is valid in access.
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (sel_ctl) begin
			nxt_rdata = {31'h0000_0000, run_ff};
		end else if (sel_lo) begin
			nxt_rdata = {28'h000_0000, count_ff[3:0]};
		end else if (sel_hi) begin
			nxt_rdata = {28'h000_0000, high_shown_ff};
		end else if (sel_en) begin
			nxt_rdata = {28'h000_0000, mask_ff};
		end else if (sel_fl) begin
			nxt_rdata = {28'h000_0000, flags};
		end
	end

	// Read data register captured in the setup phase.
	always @(posedge clock) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= nxt_rdata;
		end
	end

endmodule

// ---- pkg/ctm_consts.vh ----
// Constants for the clock timer block: offsets, fields, reset values and timing.
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH

// Register byte addresses; printed offsets are not all multiples of four, so each is an index.
`define CTM_IDX_CONTROL 16'hff78
`define CTM_IDX_COUNT_LOW 16'hff79
`define CTM_IDX_COUNT_HIGH 16'hff7a
`define CTM_IDX_IRQ_ENABLE 16'hffe6
`define CTM_IDX_IRQ_FLAGS 16'hfff6
`define CTM_ADDR_CONTROL 18'h3_fde0
`define CTM_ADDR_COUNT_LOW 18'h3_fde4
`define CTM_ADDR_COUNT_HIGH 18'h3_fde8
`define CTM_ADDR_IRQ_ENABLE 18'h3_ff98
`define CTM_ADDR_IRQ_FLAGS 18'h3_ffd8

// Control register fields.
`define CTM_BIT_RUN 0
`define CTM_BIT_CLEAR 1

// Reset values.
`define CTM_RST_COUNT 8'h00
`define CTM_RST_NIBBLE 4'h0

// Counter tap positions feeding the four interrupt sources: 16, 8, 2 and 1 Hz.
`define CTM_TAP_16HZ 3
`define CTM_TAP_8HZ 4
`define CTM_TAP_2HZ 6
`define CTM_TAP_1HZ 7

// High nibble hold window: longest time 1250 us, in ns, at 5 ns per cycle.
`define CTM_HOLD_MAX_NS 1250000
`define CTM_CLK_PERIOD_NS 5
`define CTM_HOLD_CYCLES (`CTM_HOLD_MAX_NS / `CTM_CLK_PERIOD_NS)

`endif

// ---- rtl/ctm_edge_flags.v ----
// Falling-edge detect on the four interrupt taps with write-one-to-clear factor flags.
`timescale 1ns/10ps
module ctm_edge_flags #(
	parameter N = 4
) (
	// Clock and reset.
	input wire clock,
	input wire reset,
	// Tap levels and software clear.
	input wire [N-1:0] taps,
	input wire [N-1:0] clear_mask,
	// Flag state.
	output wire [N-1:0] flags
);

	reg [N-1:0] tap_prev_ff;
	reg [N-1:0] flag_ff;
	genvar i;

	assign flags = flag_ff;

	// Each flag sets on its falling tap edge; a set wins over a same-cycle clear.
	generate
		for (i = 0; i < N; i = i + 1) begin : g_flag
			always @(posedge clock) begin
				if (reset) begin
					tap_prev_ff[i] <= 1'b0;
					flag_ff[i] <= 1'b0;
				end else begin
					tap_prev_ff[i] <= taps[i];
					if (tap_prev_ff[i] && !taps[i]) begin
						flag_ff[i] <= 1'b1;
					end else if (clear_mask[i]) begin
						flag_ff[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

endmodule

// ---- dv/ctm_clock_timer_sva.sv ----
// Port checker for the clock timer block.
`timescale 1ns/10ps
`include "ctm_consts.vh"
module ctm_clock_timer_sva #(
	parameter HOLD_CYCLES = 20,
	parameter CW = 8
) (
	// Clock and reset.
	input wire clock,
	input wire reset,
	// Stimulus.
	input wire count_tick,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	// Responses.
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [7:0] count_tap_bits,
	input wire timer_irq
);
////////////////////////////////////////////////////////////////
// Access strobes and address decode.
wire acc = psel && penable;
wire wr = acc && pwrite;
wire mapped = paddr == `CTM_ADDR_CONTROL || paddr == `CTM_ADDR_COUNT_LOW ||
	paddr == `CTM_ADDR_COUNT_HIGH || paddr == `CTM_ADDR_IRQ_ENABLE ||
	paddr == `CTM_ADDR_IRQ_FLAGS;
default clocking @(posedge clock); endclocking
default disable iff (reset);
////////////////////////////////////////////////////////////////
// Assertions.
a_ready_const: assert property (psel |-> pready) else $error("pready low");
a_reset_clears: assert property ($past(reset) |-> count_tap_bits == 8'h00 && !timer_irq)
	else $error("not clear after reset");
a_low_stable: assert property (!$past(count_tick) && !$past(wr) |-> $stable(count_tap_bits[3:0]))
	else $error("low nibble moved");
a_ctrl_upper: assert property (acc && !pwrite && paddr == `CTM_ADDR_CONTROL |-> prdata[31:1] == 0)
	else $error("control upper bits set");
a_reg_width: assert property (acc && !pwrite && mapped |-> prdata[31:4] == 0 && !pslverr)
	else $error("mapped read wrong");
a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 0))
	else $error("unmapped access accepted");
a_irq_fall: assert property ($fell(timer_irq) |-> $past(wr))
	else $error("request dropped without write");
a_irq_rise: assert property ($rose(timer_irq) |-> $past(wr) || $past(count_tick, 2))
	else $error("request without cause");
c_irq: cover property ($rose(timer_irq));
c_err: cover property (acc && pslverr);
c_tick: cover property (count_tick ##2 count_tick);
endmodule

// ---- dv/tb.sv ----
// Register-level testbench for the clock timer block.
`timescale 1ns/10ps
`include "ctm_consts.vh"
module tb;
reg clock = 0, reset = 1, count_tick = 0, psel = 0, penable = 0, pwrite = 0;
reg [17:0] paddr = 0;
reg [31:0] pwdata = 0, r;
reg sl;
wire pready, pslverr, timer_irq;
wire [31:0] prdata;
wire [7:0] count_tap_bits;
int n_errors = 0, checked = 0;
localparam [17:0] A_CT = `CTM_ADDR_CONTROL, A_LO = `CTM_ADDR_COUNT_LOW;
localparam [17:0] A_HI = `CTM_ADDR_COUNT_HIGH, A_EN = `CTM_ADDR_IRQ_ENABLE;
localparam [17:0] A_FL = `CTM_ADDR_IRQ_FLAGS;
ctm_clock_timer #(.HOLD_CYCLES(20), .CW(8)) DUT (.clock(clock), .reset(reset),
	.count_tick(count_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .count_tap_bits(count_tap_bits), .timer_irq(timer_irq));
////////////////////////////////////////////////////////////////
// Clock, 5 ns period.
initial begin
	forever #2.5 clock = ~clock;
end
// Compare and count.
task chk(input string n, input [31:0] s, input [31:0] e);
	checked++;
	if (s !== e) begin
		n_errors++;
		$display("[FAIL] %s expected %h seen %h", n, e, s);
	end
endtask
// One APB transfer; entered just after a rising edge.
task acc(input [17:0] a, input w, input [31:0] d);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clock);
	penable <= 1;
	do @(posedge clock); while (pready !== 1'b1);
	r = prdata;
	sl = pslverr;
	psel <= 0;
	penable <= 0;
	@(posedge clock);
endtask
task rd(input [17:0] a, input [31:0] e);
	acc(a, 0, 0);
	chk("prdata", r, e);
endtask
// Prescaler pulses, one cycle high then one cycle low (two cycles apart), standing in for a correctly set prescaler.
task tick(input int n);
	repeat (n) begin
		count_tick <= 1;
		@(posedge clock);
		count_tick <= 0;
		@(posedge clock);
	end
endtask
task final_report;
	$display("errors %0d checks %0d", n_errors, checked);
	if (n_errors == 0 && checked > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////
// Watchdog.
initial begin
	#100000;
	n_errors++;
	final_report;
end
// Main sequence.
initial begin
	repeat (6) @(posedge clock);
	reset <= 0;
	@(posedge clock);
	rd(A_CT, 0);
	rd(A_LO, 0);
	rd(A_HI, 0);
	rd(A_EN, 0);
	rd(A_FL, 0);
	acc(A_LO, 1, 32'h0000_000f);
	acc(A_HI, 1, 32'h0000_000f);
	rd(A_LO, 0);
	acc(A_CT, 1, 32'h0000_000f);
	rd(A_CT, 1);
	tick(5);
	rd(A_LO, 5);
	chk("count_tap_bits", count_tap_bits, 5);
	tick(11);
	rd(A_HI, 1);
	rd(A_FL, 1);
	chk("irq", timer_irq, 0);
	acc(A_EN, 1, 32'h0000_0001);
	acc(A_FL, 1, 32'h0000_0000);
	rd(A_FL, 1);
	chk("irq", timer_irq, 1);
	acc(A_FL, 1, 32'h0000_0001);
	rd(A_FL, 0);
	chk("irq", timer_irq, 0);
	acc(A_CT, 1, 32'h0000_0000);
	tick(3);
	rd(A_LO, 0);
	acc(A_CT, 1, 32'h0000_0002);
	rd(A_HI, 0);
	tick(2);
	rd(A_CT, 0);
	rd(A_LO, 0);
	acc(A_CT, 1, 32'h0000_0001);
	tick(15);
	rd(A_LO, 15);
	tick(1);
	rd(A_HI, 0);
	rd(A_HI, 1);
	rd(A_LO, 0);
	tick(16);
	rd(A_HI, 2);
	chk("count_tap_bits", count_tap_bits, 8'h20);
	acc(A_FL, 1, 32'h0000_000f);
	tick(256);
	rd(A_FL, 15);
	acc(A_EN, 1, 32'h0000_000f);
	rd(A_EN, 15);
	chk("irq", timer_irq, 1);
	acc(A_CT, 1, 32'h0000_0003);
	tick(2);
	rd(A_LO, 2);
	rd(18'h0_0010, 0);
	chk("pslverr", sl, 1);
	final_report;
end
endmodule
bind ctm_clock_timer ctm_clock_timer_sva #(.HOLD_CYCLES(HOLD_CYCLES), .CW(CW)) u_sva (
	.clock(clock), .reset(reset), .count_tick(count_tick), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.count_tap_bits(count_tap_bits), .timer_irq(timer_irq));
